// ---- hdl/clk_mon_pkg.sv ----
// Shared constants for the clock-source supervisor: register map, field layout,
// oscillator modes, states and timing.
// Assumes a 50 MHz system clock and 32-bit APB data.
package clk_mon_pkg;

	// ********************************
	// Timing
	// ********************************
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned POWER_UP_DELAY_TIMER_TIME_MS = 64;
	localparam int unsigned WARM_TIME_NS = 2000;
	localparam int unsigned POWER_UP_DELAY_TIMER_CYC_DEF = POWER_UP_DELAY_TIMER_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned WARM_CYC_DEF = (WARM_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned OST_COUNT_DEF = 1024;
	localparam int unsigned FAIL_SAFE_MONITOR_DIV = 64;
	localparam int unsigned CNT_W = 22;

	// ********************************
	// Register map
	// ********************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_CFG = 8'h08;
	localparam logic [7:0] ADDR_FLAG = 8'h0c;
	localparam logic [7:0] ADDR_IRQEN = 8'h10;
	localparam int unsigned CTRL_SCS_LSB = 0;
	localparam int unsigned CTRL_INTERNAL_FREQ_SELECT_LSB = 3;
	localparam int unsigned CFG_INT_EXT_SWITCHOVER_CFG_BIT = 3;
	localparam int unsigned CFG_FAIL_MONITOR_ENABLE_CFG_BIT = 4;
	localparam int unsigned CFG_PWRTEN_BIT = 5;
	localparam logic [3:0] INTERNAL_FREQ_SELECT_RESET = 4'h7;
	localparam logic [1:0] SCS_PRIMARY = 2'h0;
	localparam logic [1:0] SCS_TIMER_OSC = 2'h1;
	localparam logic [2:0] CFG_OSC_RESET = 3'h1;

	// ********************************
	// Oscillator modes and sources
	// ********************************
	localparam logic [2:0] MODE_LP = 3'h0;
	localparam logic [2:0] MODE_XT = 3'h1;
	localparam logic [2:0] MODE_HS = 3'h2;
	localparam logic [2:0] MODE_EC = 3'h3;
	localparam logic [2:0] MODE_INT = 3'h4;

	typedef enum logic [1:0] {SRC_NONE = 2'h0, SRC_INT = 2'h1, SRC_EXT = 2'h2, SRC_T1 = 2'h3} clk_src_t;

	// Gray steps along the start-up path
	typedef enum logic [3:0] {
		ST_POWER_UP_DELAY_TIMER = 4'h0, ST_COUNT = 4'h1, ST_SYNC = 4'h3, ST_HOLD = 4'h2, ST_RUN_EXT = 4'h6,
		ST_FAILED = 4'h7, ST_WARM = 4'h4, ST_RUN_INT = 4'h5, ST_SLEEP = 4'h8
	} mon_state_t;

endpackage

// ---- hdl/fail_det_if.sv ----
// Link between the supervisor sequencer and its fail detector.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
interface fail_det_if;
	logic extFall;
	logic lfRise;
	logic monitorArm;
	logic failPulse;
	modport sequencer (output extFall, output lfRise, output monitorArm, input failPulse);
	modport detector (input extFall, input lfRise, input monitorArm, output failPulse);
endinterface

// ---- hdl/fail_detector.sv ----
// Fail-safe detector: divides the low-frequency oscillator into a sample clock and
// watches a latch that the external clock sets. Assumes sampled edge pulses on sys_clk.
`timescale 1ns/1ps
module fail_detector import clk_mon_pkg::*; #(
	parameter int unsigned DIV = FAIL_SAFE_MONITOR_DIV
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	fail_det_if.detector det
);
	localparam int unsigned HALF = DIV / 2;
	localparam int unsigned DW = $clog2(HALF);

	logic [DW-1:0] divCnt_reg;
	logic sampleClk_reg;
	logic seenLow_reg;
	logic fail_reg;
	logic halfEnd;

	assign halfEnd = det.lfRise && (divCnt_reg == DW'(HALF - 1));

	// ********************************
	// Sample clock divider
	// ********************************
	// Half period is HALF slow edges, so a full period is DIV
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			divCnt_reg <= '0;
			sampleClk_reg <= 1'b0;
		end else if (halfEnd) begin
			divCnt_reg <= '0;
			sampleClk_reg <= ~sampleClk_reg;
		end else if (det.lfRise) begin
			divCnt_reg <= divCnt_reg + DW'(1);
		end
	end

	// Latch: set by external low-going edge, cleared on sample rising edge; set wins
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			seenLow_reg <= 1'b1;
		end else if (det.extFall || !det.monitorArm) begin
			seenLow_reg <= 1'b1;
		end else if (halfEnd && !sampleClk_reg) begin
			seenLow_reg <= 1'b0;
		end
	end

	// A whole high half of the sample clock with no low edge is a failure
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			fail_reg <= 1'b0;
		end else begin
			fail_reg <= halfEnd && sampleClk_reg && !seenLow_reg && !det.extFall && det.monitorArm;
		end
	end

	assign det.failPulse = fail_reg;

endmodule // fail_detector

// ---- hdl/two_speed_start_fail_safe_monitor.sv ----
// Two-speed start-up sequencer and fail-safe clock monitor with an APB register file.
// Assumes oscillator levels and request pulses are already synchronous to sys_clk.
//
// Contract
// - two-speed needs switchover bit, select 00, crystal
// - start after reset, power-up delay, and wake
// - run internal oscillator at selected frequency
// - count 1024 external cycles before switching
// - sync internal fall, set status, hold, switch
// - status bit shows external or internal source
// - timer or crystal targets wait 1024 cycles
// - idle internal oscillator gets warm-up delay
// - monitor enabled by config bit, all externals
// - no failure detection before counter expires
// - sample clock is slow oscillator over 64
// - external fall sets latch, sample rise clears
// - failure when sample half passes without low
// - on failure use internal clock, set flag
// - interrupt when flag and enable both set
// - stay internal until software restarts external
// - reset, sleep or select change clears condition
// - select change restarts counter, clear at timeout
// - flag cannot clear while condition active
// - counter skipped for external clock and RC
// - monitor enable also enables two-speed start-up
// - sleep aborts counter, status stays clear
// - select field resets to 00
`timescale 1ns/1ps
module two_speed_start_fail_safe_monitor import clk_mon_pkg::*; #(
	parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES = POWER_UP_DELAY_TIMER_CYC_DEF,
	parameter int unsigned WARM_CYCLES = WARM_CYC_DEF,
	parameter int unsigned OST_COUNT = OST_COUNT_DEF
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic extClk,
	input wire logic timerOscClk,
	input wire logic intClk,
	input wire logic lfOsc,
	input wire logic intOscRunning,
	input wire logic sleepReq,
	input wire logic wakeReq,
	output logic [1:0] clkSource,
	output logic clkHoldLow,
	output logic [3:0] intFreqSel,
	output logic oscFailIrq
);

	// ********************************
	// Declarations
	// ********************************
	logic [1:0] sysClockSelect_reg;
	logic [3:0] intFreqSelect_reg;
	logic [2:0] oscCfg_reg;
	logic int_ext_switchover_cfg_reg;
	logic fail_monitor_enable_cfg_reg;
	logic pwrtEn_reg;
	logic irqEnable_reg;
	logic oscFailFlag_reg;
	logic startupDone_reg;
	logic failCond_reg;
	mon_state_t state_reg;
	mon_state_t state_next;
	logic [CNT_W-1:0] cnt_reg;
	logic extPrev_reg;
	logic t1Prev_reg;
	logic intPrev_reg;
	logic lfPrev_reg;
	clk_src_t clkSource_reg;
	logic clkHoldLow_reg;
	logic irq_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic wrEn;
	logic rdEn;
	logic mapped;
	logic scsChange;
	logic [1:0] scsNew;
	logic flagClearReq;
	logic extFall;
	logic t1Fall;
	logic intFall;
	logic tgtFall;
	logic isCrystal;
	logic twoSpeed;
	logic failEvent;
	logic pwrtDone;
	logic warmDone;
	logic ostDone;
	fail_det_if detLink ();

	// ********************************
	// Edges of the sampled oscillators
	// ********************************
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			extPrev_reg <= 1'b0;
			t1Prev_reg <= 1'b0;
			intPrev_reg <= 1'b0;
			lfPrev_reg <= 1'b0;
		end else begin
			extPrev_reg <= extClk;
			t1Prev_reg <= timerOscClk;
			intPrev_reg <= intClk;
			lfPrev_reg <= lfOsc;
		end
	end

	assign extFall = extPrev_reg && !extClk;
	assign t1Fall = t1Prev_reg && !timerOscClk;
	assign intFall = intPrev_reg && !intClk;
	// The timer oscillator replaces the primary one only when it is selected
	assign tgtFall = (sysClockSelect_reg == SCS_TIMER_OSC) ? t1Fall : extFall;

	// Mode decode
	assign isCrystal = (oscCfg_reg == MODE_LP) || (oscCfg_reg == MODE_XT) || (oscCfg_reg == MODE_HS);
	assign twoSpeed = (int_ext_switchover_cfg_reg || fail_monitor_enable_cfg_reg) && (sysClockSelect_reg == SCS_PRIMARY) && isCrystal;

	// ********************************
	// APB decode
	// ********************************
	// Zero wait state beyond the registered ready; writes land at the completing edge
	assign wrEn = psel && penable && pready_reg && pwrite;
	assign rdEn = psel && !penable && !pwrite;
	assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_CFG)
		|| (paddr == ADDR_FLAG) || (paddr == ADDR_IRQEN);
	assign scsNew = pwdata[CTRL_SCS_LSB +: 2];
	assign scsChange = wrEn && (paddr == ADDR_CTRL) && (scsNew != sysClockSelect_reg);
	assign flagClearReq = wrEn && (paddr == ADDR_FLAG) && pwdata[0];

	// Ready and error are registered, so every access takes exactly one access cycle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= psel && !penable && !pready_reg;
			pslverr_reg <= psel && !penable && !pready_reg && !mapped;
		end
	end

	// Read data captured in the setup cycle; unmapped reads return zero
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata_reg <= '0;
		end else if (rdEn) begin
			case (paddr)
				ADDR_CTRL: prdata_reg <= {25'h0, intFreqSelect_reg, 1'b0, sysClockSelect_reg};
				ADDR_STATUS: prdata_reg <= {28'h0, clkSource_reg, failCond_reg, startupDone_reg};
				ADDR_CFG: prdata_reg <= {26'h0, pwrtEn_reg, fail_monitor_enable_cfg_reg, int_ext_switchover_cfg_reg, oscCfg_reg};
				ADDR_FLAG: prdata_reg <= {31'h0, oscFailFlag_reg};
				ADDR_IRQEN: prdata_reg <= {31'h0, irqEnable_reg};
				default: prdata_reg <= '0;
			endcase
		end
	end

	// ********************************
	// Software-owned registers
	// ********************************
	// Select field returns to primary on every reset
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sysClockSelect_reg <= SCS_PRIMARY;
			intFreqSelect_reg <= INTERNAL_FREQ_SELECT_RESET;
		end else if (wrEn && paddr == ADDR_CTRL) begin
			sysClockSelect_reg <= scsNew;
			intFreqSelect_reg <= pwdata[CTRL_INTERNAL_FREQ_SELECT_LSB +: 4];
		end
	end

	// Oscillator mode is read when a start is routed; the enable bits take effect at once
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			oscCfg_reg <= CFG_OSC_RESET;
			int_ext_switchover_cfg_reg <= 1'b1;
			fail_monitor_enable_cfg_reg <= 1'b1;
			pwrtEn_reg <= 1'b0;
		end else if (wrEn && paddr == ADDR_CFG) begin
			oscCfg_reg <= pwdata[2:0];
			int_ext_switchover_cfg_reg <= pwdata[CFG_INT_EXT_SWITCHOVER_CFG_BIT];
			fail_monitor_enable_cfg_reg <= pwdata[CFG_FAIL_MONITOR_ENABLE_CFG_BIT];
			pwrtEn_reg <= pwdata[CFG_PWRTEN_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irqEnable_reg <= 1'b0;
		end else if (wrEn && paddr == ADDR_IRQEN) begin
			irqEnable_reg <= pwdata[0];
		end
	end

	// ********************************
	// Sequencer
	// ********************************
	assign pwrtDone = !pwrtEn_reg || (cnt_reg == CNT_W'(POWER_UP_DELAY_TIMER_CYCLES - 1));
	assign warmDone = cnt_reg == CNT_W'(WARM_CYCLES - 1);
	assign ostDone = tgtFall && (cnt_reg == CNT_W'(OST_COUNT - 1));
	assign failEvent = detLink.failPulse && state_reg == ST_RUN_EXT;

	// Where a fresh start goes for a given select value
	function automatic mon_state_t route(input logic [1:0] sys_clock_select, input logic [2:0] mode, input logic intRun);
		if (sys_clock_select[1] || (sys_clock_select == SCS_PRIMARY && mode == MODE_INT)) begin
			route = intRun ? ST_RUN_INT : ST_WARM;
		end else if (sys_clock_select == SCS_TIMER_OSC || mode < MODE_EC) begin
			route = ST_COUNT;
		end else begin
			route = ST_RUN_EXT;
		end
	endfunction

	// Sleep beats everything, then a select change, then the normal walk
	always_comb begin
		state_next = state_reg;
		if (sleepReq) begin
			state_next = ST_SLEEP;
		end else if (scsChange && state_reg != ST_POWER_UP_DELAY_TIMER && state_reg != ST_SLEEP) begin
			state_next = route(scsNew, oscCfg_reg, intOscRunning);
		end else begin
			case (state_reg)
				ST_POWER_UP_DELAY_TIMER: if (pwrtDone) state_next = route(sysClockSelect_reg, oscCfg_reg, intOscRunning);
				ST_SLEEP: if (wakeReq) state_next = route(sysClockSelect_reg, oscCfg_reg, intOscRunning);
				ST_WARM: if (warmDone) state_next = ST_RUN_INT;
				ST_COUNT: if (ostDone) state_next = ST_SYNC;
				ST_SYNC: if (intFall) state_next = ST_HOLD;
				ST_HOLD: if (tgtFall) state_next = ST_RUN_EXT;
				ST_RUN_EXT: if (failEvent) state_next = ST_FAILED;
				ST_RUN_INT: state_next = ST_RUN_INT;
				ST_FAILED: state_next = ST_FAILED;
				default: state_next = ST_POWER_UP_DELAY_TIMER;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_POWER_UP_DELAY_TIMER;
		end else begin
			state_reg <= state_next;
		end
	end

	// One counter serves power-up delay, warm-up and start-up counting
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg <= '0;
		end else if (state_next != state_reg || scsChange) begin
			cnt_reg <= '0;
		end else if (state_reg == ST_POWER_UP_DELAY_TIMER || state_reg == ST_WARM || (state_reg == ST_COUNT && tgtFall)) begin
			cnt_reg <= cnt_reg + CNT_W'(1);
		end
	end

	// ********************************
	// Status and fail condition
	// ********************************
	// Set at the internal-edge sync of a primary crystal start, or whenever external run with primary selected is next
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			startupDone_reg <= 1'b0;
		end else if (sleepReq || scsChange || failEvent) begin
			startupDone_reg <= 1'b0;
		end else if (state_reg == ST_SYNC && intFall && sysClockSelect_reg == SCS_PRIMARY) begin
			startupDone_reg <= 1'b1;
		end else if (state_next == ST_RUN_EXT && sysClockSelect_reg == SCS_PRIMARY) begin
			startupDone_reg <= 1'b1;
		end
	end

	// Condition survives a select change to a counted source until its timeout
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			failCond_reg <= 1'b0;
		end else if (sleepReq) begin
			failCond_reg <= 1'b0;
		end else if (failEvent) begin
			failCond_reg <= 1'b1;
		end else if (scsChange && route(scsNew, oscCfg_reg, intOscRunning) != ST_COUNT) begin
			failCond_reg <= 1'b0;
		end else if (state_reg == ST_COUNT && ostDone) begin
			failCond_reg <= 1'b0;
		end
	end

	// Sticky flag; a new failure wins over a clear in the same cycle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			oscFailFlag_reg <= 1'b0;
		end else if (failEvent) begin
			oscFailFlag_reg <= 1'b1;
		end else if (flagClearReq && !failCond_reg) begin
			oscFailFlag_reg <= 1'b0;
		end
	end

	// ********************************
	// Clock source outputs
	// ********************************
	// Without two-speed or a pending fail condition, nothing runs while the counter qualifies the oscillator
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			clkSource_reg <= SRC_NONE;
			clkHoldLow_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			clkHoldLow_reg <= state_next == ST_HOLD;
			irq_reg <= oscFailFlag_reg && irqEnable_reg;
			case (state_next)
				ST_COUNT, ST_SYNC: clkSource_reg <= (twoSpeed || failCond_reg) ? SRC_INT : SRC_NONE;
				ST_RUN_EXT: clkSource_reg <= (sysClockSelect_reg == SCS_TIMER_OSC) ? SRC_T1 : SRC_EXT;
				ST_RUN_INT, ST_FAILED: clkSource_reg <= SRC_INT;
				default: clkSource_reg <= SRC_NONE;
			endcase
		end
	end

	// ********************************
	// Fail detector
	// ********************************
	// Armed only once running from an external source, counted or EC, with the monitor bit set
	assign detLink.extFall = tgtFall;
	assign detLink.lfRise = !lfPrev_reg && lfOsc;
	assign detLink.monitorArm = fail_monitor_enable_cfg_reg && state_reg == ST_RUN_EXT;

	fail_detector #(.DIV(FAIL_SAFE_MONITOR_DIV)) failDet (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.det(detLink.detector)
	);

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign clkSource = clkSource_reg;
	assign clkHoldLow = clkHoldLow_reg;
	assign intFreqSel = intFreqSelect_reg;
	assign oscFailIrq = irq_reg;

endmodule // two_speed_start_fail_safe_monitor

// ---- test/clk_mon_props.sv ----
// Checker for the clock supervisor: APB answer timing and clock switch rules.
// Assumes it is bound to the supervisor top module and sees its ports only.
`timescale 1ns/1ps
module clk_mon_props import clk_mon_pkg::*; (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sleepReq,
	input wire logic [1:0] clkSource,
	input wire logic clkHoldLow,
	input wire logic [3:0] intFreqSel
);
	// ****************
	// Helpers
	// ****************
	logic [3:0] wrFreq;
	logic apbDone;
	logic mapped;
	// Named once so each property stays short
	assign wrFreq = pwdata[6:3];
	assign apbDone = psel && penable && pready;
	assign mapped = paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_CFG, ADDR_FLAG, ADDR_IRQEN};
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	// ****************
	// Properties
	// ****************
	apb_answer_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
	ready_single_a: assert property (pready |=> !pready) else $error("ready held too long");
	unmapped_err_a: assert property (apbDone && !mapped |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (apbDone && mapped |-> !pslverr) else $error("mapped access refused");
	freq_write_a: assert property (apbDone && pwrite && paddr == ADDR_CTRL |=> intFreqSel == $past(wrFreq))
		else $error("frequency select not taken");
	reset_freq_a: assert property ($rose(reset_n) |-> intFreqSel == INTERNAL_FREQ_SELECT_RESET)
		else $error("frequency select reset value wrong");
	hold_not_ext_a: assert property (clkHoldLow |-> clkSource != SRC_EXT)
		else $error("external source while clock held");
	hold_ends_ext_a: assert property ($fell(clkHoldLow) && !sleepReq |-> ##[0:2] clkSource == SRC_EXT)
		else $error("hold ended without switch");
	sleep_no_ext_a: assert property (sleepReq |-> ##2 clkSource != SRC_EXT)
		else $error("external source kept in sleep");
endmodule // clk_mon_props

bind two_speed_start_fail_safe_monitor clk_mon_props u_props (.sys_clk(sys_clk), .reset_n(reset_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sleepReq(sleepReq), .clkSource(clkSource),
	.clkHoldLow(clkHoldLow), .intFreqSel(intFreqSel));

// ---- test/xtal_model.sv ----
// Behavioural crystal at the far side of the supervisor.
// Assumes sys_clk as time base; a failed crystal stands at its last level.
`timescale 1ns/1ps
module xtal_model #(
	parameter int HALF = 3
) (
	input wire logic sys_clk,
	input wire logic run,
	output logic extClk
);
	int cnt = 0;
	initial extClk = 1'b0;
	// A dead crystal stops swinging rather than going idle to a pull level
	always @(posedge sys_clk) begin
		if (run) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1) extClk <= ~extClk;
		end
	end
endmodule // xtal_model

// ---- test/testbench.sv ----
// Self-checking bench for the two-speed start-up and fail-safe supervisor.
// Assumes short counts via parameters and a crystal model on the far side.
`timescale 1ns/1ps
module testbench import clk_mon_pkg::*; ();
	logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, rErr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic extClk, intClk, lfOsc, sleepReq, wakeReq, xRun, clkHoldLow, oscFailIrq, intRun;
	logic [1:0] clkSource;
	logic [3:0] intFreqSel, f;
	logic [2:0] divCnt = 3'h0;
	int n_mismatch = 0;
	int n_compared = 0;
	int seed = 32'h28a8;
	int mCtrl = 32'h38;
	int cfgs[2] = '{32'h01, 32'h11};
	logic [3:0] srcs[2] = '{4'h0, 4'h1};

	// ****************
	// Clocks and parts
	// ****************
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Internal oscillators kept slow so one sample half spans 256 cycles
	always @(posedge sys_clk) begin
		divCnt <= divCnt + 3'h1;
		intClk <= divCnt[0];
		lfOsc <= divCnt[2];
	end
	xtal_model #(.HALF(3)) u_xtal (.sys_clk(sys_clk), .run(xRun), .extClk(extClk));
	two_speed_start_fail_safe_monitor #(.POWER_UP_DELAY_TIMER_CYCLES(50), .WARM_CYCLES(4), .OST_COUNT(16)) u_dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.extClk(extClk), .timerOscClk(1'b0), .intClk(intClk), .lfOsc(lfOsc), .intOscRunning(intRun),
		.sleepReq(sleepReq), .wakeReq(wakeReq), .clkSource(clkSource), .clkHoldLow(clkHoldLow),
		.intFreqSel(intFreqSel), .oscFailIrq(oscFailIrq));

	// ****************
	// Tasks
	// ****************
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		rdat = prdata;
		rErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e, input logic eErr);
		apb(1'b0, a, 32'h0);
		n_compared++;
		if (rdat !== e || rErr !== eErr) begin
			n_mismatch++;
			$display("CHECK FAILED %0t read %h got %h exp %h", $time, a, rdat, e);
		end
	endtask
	task automatic chk_pin(input logic [3:0] g, input logic [3:0] e, input string s);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, s, g, e);
		end
	endtask
	task automatic wait_src(input logic [1:0] s);
		while (clkSource !== s) @(posedge sys_clk);
		chk_pin({2'b00, clkSource}, {2'b00, s}, "source");
	endtask
	// One-cycle request pulse; a clock edge always passes before the next
	task automatic pulse(input logic sl);
		@(posedge sys_clk);
		if (sl) sleepReq <= 1'b1;
		else wakeReq <= 1'b1;
		@(posedge sys_clk);
		sleepReq <= 1'b0;
		wakeReq <= 1'b0;
	endtask
	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ****************
	// Sequence
	// ****************
	initial begin
		{psel, penable, pwrite, sleepReq, wakeReq, reset_n} = '0;
		paddr = '0;
		pwdata = '0;
		xRun = 1'b1;
		intRun = 1'b1;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		chk_reg(ADDR_CTRL, 32'h38, 1'b0);
		chk_reg(ADDR_CFG, 32'h19, 1'b0);
		chk_reg(ADDR_STATUS, 32'h4, 1'b0);
		chk_reg(8'h14, 32'h0, 1'b1);
		wait_src(SRC_EXT);
		chk_reg(ADDR_STATUS, 32'h9, 1'b0);
		$display("test startup done");
		// Random frequency choices seen at the port and read back
		repeat (3) begin
			f = 4'($random(seed));
			mCtrl = {25'h0, f, 3'h0};
			apb(1'b1, ADDR_CTRL, 32'(mCtrl));
			@(posedge sys_clk);
			chk_pin(intFreqSel, f, "freq");
			chk_reg(ADDR_CTRL, 32'(mCtrl), 1'b0);
		end
		$display("test frequency done");
		// Crystal dies while running external
		apb(1'b1, ADDR_IRQEN, 32'h1);
		xRun <= 1'b0;
		wait_src(SRC_INT);
		repeat (2) @(posedge sys_clk);
		chk_pin({3'h0, oscFailIrq}, 4'h1, "irq");
		chk_reg(ADDR_STATUS, 32'h6, 1'b0);
		apb(1'b1, ADDR_FLAG, 32'h1);
		chk_reg(ADDR_FLAG, 32'h1, 1'b0);
		apb(1'b1, ADDR_IRQEN, 32'h0);
		repeat (2) @(posedge sys_clk);
		chk_pin({3'h0, oscFailIrq}, 4'h0, "masked");
		xRun <= 1'b1;
		repeat (60) @(posedge sys_clk);
		chk_pin({2'b00, clkSource}, {2'b00, SRC_INT}, "stays");
		// Internal oscillator reported idle, so the switch must pass through warm-up
		intRun <= 1'b0;
		apb(1'b1, ADDR_CTRL, 32'(mCtrl | 2));
		chk_reg(ADDR_STATUS, 32'h0, 1'b0);
		wait_src(SRC_INT);
		intRun <= 1'b1;
		chk_reg(ADDR_STATUS, 32'h4, 1'b0);
		apb(1'b1, ADDR_FLAG, 32'h1);
		chk_reg(ADDR_FLAG, 32'h0, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'(mCtrl));
		wait_src(SRC_EXT);
		$display("test failure done");
		// Sleep and wake with two-speed off, then on through the monitor enable
		foreach (cfgs[i]) begin
			apb(1'b1, ADDR_CFG, 32'(cfgs[i]));
			pulse(1'b1);
			pulse(1'b0);
			repeat (4) @(posedge sys_clk);
			chk_pin({2'b00, clkSource}, srcs[i], "count source");
			pulse(1'b1);
			apb(1'b0, ADDR_STATUS, 32'h0);
			chk_pin({3'h0, rdat[0]}, 4'h0, "aborted");
			pulse(1'b0);
			wait_src(SRC_EXT);
		end
		$display("test sleep done");
		give_verdict();
	end

	// Hang guard, well beyond the thousand or so cycles the tests need
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		$display("CHECK FAILED %0t timeout", $time);
		give_verdict();
	end
endmodule // testbench
